//--- verilog/cbs_pkg.sv
// Constants for the bus-cycle sequencer.
// Assumes a 16-bit address bus and 8-bit data bus.
package cbs_pkg;
    localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;
    localparam logic [7:0] OP_SELF_TEST = 8'h00;
    localparam logic [7:0] OP_PAGE_Y = 8'h18;
    localparam logic [7:0] OP_PAGE_CD = 8'h1A;
    localparam logic [7:0] OP_PAGE_CPY_D = 8'hCD;
    localparam logic [7:0] OP2_LOAD_Y_IMM = 8'hEC;
    localparam logic [7:0] OP2_CMP_IMM = 8'h8C;
    localparam logic [7:0] OP2_CPD_IMM = 8'h83;
    localparam logic [7:0] OP_SUB_D_IMM = 8'h83;
    localparam logic [7:0] OP_ADD_D_IMM = 8'hC3;
    localparam logic [7:0] OP_CMP_X_IMM = 8'h8C;
    localparam logic [7:0] OP_LD_D_IMM = 8'hCC;
    localparam logic [7:0] OP_LD_S_IMM = 8'h8E;
    localparam logic [7:0] OP_LD_X_IMM = 8'hCE;
    localparam logic [7:0] OP_STORE_A_DIR = 8'h97;
    localparam logic [7:0] OP_STORE_B_DIR = 8'hD7;
    localparam logic [3:0] GRP_IMM8_A = 4'h8;
    localparam logic [3:0] GRP_IMM8_B = 4'hC;
    localparam logic [3:0] GRP_DIR8_A = 4'h9;
    localparam logic [3:0] GRP_DIR8_B = 4'hD;
    localparam logic [15:0] RESET_PC = 16'h0000;

    typedef enum logic [6:0] {
        ST_FETCH = 7'b000_0001,
        ST_PAGE2 = 7'b000_0010,
        ST_OPND = 7'b000_0100,
        ST_OPND_LO = 7'b000_1000,
        ST_DUMMY = 7'b001_0000,
        ST_DIRECT = 7'b010_0000,
        ST_TEST = 7'b100_0000
    } cbs_state_e;
endpackage : cbs_pkg

//--- verilog/cbs_sequencer.sv
// Bus-cycle sequencer: one bus cycle per rising ref_clk edge.
// Assumes an asynchronous memory returning data_in in the same cycle as addr.
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer
    import cbs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] data_in,
    input wire logic [7:0] acc_a,
    input wire logic [7:0] acc_b,
    output logic [15:0] addr,
    output logic rd_wr,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic [7:0] opcode,
    output logic opnd_valid,
    output logic [7:0] opnd
);
    ////////////////////////////////////////////////////////////////////
    cbs_state_e state, next_state;
    logic [15:0] pc, next_pc;
    logic [15:0] next_addr;
    logic next_rd_wr, next_data_oe, next_opnd_valid;
    logic [7:0] next_data_out, next_opcode, next_opnd;
    logic [1:0] left, next_left;
    logic dummy_end, next_dummy_end;
    logic is_store, next_is_store;
    logic [1:0] test_n, next_test_n;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] inc(input logic [15:0] a);
        inc = a + 16'h0001;
    endfunction : inc

    // 8-bit arithmetic, logic, compare and load share these low nibbles
    function automatic logic is_alu8(input logic [7:0] op);
        case (op[3:0])
            4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA,
            4'hB: begin
                is_alu8 = 1'b1;
            end
            default: begin
                is_alu8 = 1'b0;
            end
        endcase
    endfunction : is_alu8

    // Accumulator stores exist in direct mode only
    function automatic logic is_store8(input logic [7:0] op);
        is_store8 = (op == OP_STORE_A_DIR) || (op == OP_STORE_B_DIR);
    endfunction : is_store8

    ////////////////////////////////////////////////////////////////////
    // Data bus is sampled in the cycle whose address is on addr.
    always_comb begin
        next_state = state;
        next_pc = pc;
        next_addr = addr;
        next_rd_wr = 1'b1;
        next_data_out = data_out;
        next_data_oe = 1'b0;
        next_opcode = opcode;
        next_opnd_valid = 1'b0;
        next_opnd = opnd;
        next_left = left;
        next_dummy_end = dummy_end;
        next_is_store = is_store;
        next_test_n = test_n;
        case (state)
            ST_FETCH: begin
                next_opcode = data_in;
                next_pc = inc(pc);
                next_addr = inc(pc);
                next_dummy_end = 1'b0;
                next_is_store = 1'b0;
                next_state = ST_OPND;
                next_left = 2'd0;
                if (data_in == OP_SELF_TEST) begin
                    next_test_n = 2'd0;
                    next_state = ST_TEST;
                end else if (data_in == OP_PAGE_Y || data_in == OP_PAGE_CD
                        || data_in == OP_PAGE_CPY_D) begin
                    next_state = ST_PAGE2;
                end else if (data_in == OP_LD_D_IMM || data_in == OP_LD_S_IMM
                        || data_in == OP_LD_X_IMM) begin
                    next_left = 2'd1;
                end else if (data_in == OP_ADD_D_IMM
                        || data_in == OP_SUB_D_IMM
                        || data_in == OP_CMP_X_IMM) begin
                    next_left = 2'd1;
                    next_dummy_end = 1'b1;
                end else if ((data_in[7:4] == GRP_DIR8_A
                        || data_in[7:4] == GRP_DIR8_B)
                        && (is_alu8(data_in) || is_store8(data_in))) begin
                    next_state = ST_DIRECT;
                    next_is_store = is_store8(data_in);
                end else if ((data_in[7:4] == GRP_IMM8_A
                        || data_in[7:4] == GRP_IMM8_B)
                        && is_alu8(data_in)) begin
                    next_left = 2'd0;
                end else begin
                    // Other opcodes belong to other sequencers; skip them
                    next_state = ST_FETCH;
                end
            end
            ST_PAGE2: begin
                next_opcode = data_in;
                next_pc = inc(pc);
                next_addr = inc(pc);
                next_left = 2'd1;
                next_state = ST_OPND;
                next_dummy_end = (data_in == OP2_CMP_IMM)
                    || (data_in == OP2_CPD_IMM);
                if (!(data_in == OP2_LOAD_Y_IMM || next_dummy_end)) begin
                    next_state = ST_FETCH;
                end
            end
            ST_OPND: begin
                next_opnd = data_in;
                next_opnd_valid = 1'b1;
                next_pc = inc(pc);
                next_addr = inc(pc);
                if (left != 2'd0) begin
                    next_left = left - 2'd1;
                end else if (dummy_end) begin
                    next_addr = DUMMY_ADDR;
                    next_state = ST_DUMMY;
                end else begin
                    next_state = ST_FETCH;
                end
            end
            ST_DUMMY: begin
                next_addr = pc;
                next_state = ST_FETCH;
            end
            ST_DIRECT: begin
                next_addr = {DIRECT_PAGE, data_in};
                if (is_store) begin
                    next_pc = inc(pc);
                    next_rd_wr = 1'b0;
                    next_data_oe = 1'b1;
                    next_data_out = opcode[6] ? acc_b : acc_a;
                    next_state = ST_DUMMY;
                end else begin
                    // Pc stays put: the operand cycle steps it past
                    // operand read
                    next_state = ST_OPND;
                    next_left = 2'd0;
                    next_dummy_end = 1'b0;
                end
            end
            ST_TEST: begin
                if (test_n == 2'd0) begin
                    next_test_n = 2'd1;
                end else begin
                    next_addr = inc(addr);
                end
            end
            default: begin
                next_state = ST_FETCH;
            end
        endcase
        // Last operand read hands over to the next opcode unless dummy_end sends it to ST_DUMMY first
        if (state == ST_OPND && next_state == ST_FETCH) begin
            next_addr = inc(pc);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reset parks the bus on an opcode fetch at RESET_PC
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_FETCH;
            pc <= RESET_PC;
            addr <= RESET_PC;
            rd_wr <= 1'b1;
            data_out <= 8'h00;
            data_oe <= 1'b0;
            opcode <= 8'h00;
            opnd_valid <= 1'b0;
            opnd <= 8'h00;
            left <= 2'd0;
            dummy_end <= 1'b0;
            is_store <= 1'b0;
            test_n <= 2'd0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            addr <= next_addr;
            rd_wr <= next_rd_wr;
            data_out <= next_data_out;
            data_oe <= next_data_oe;
            opcode <= next_opcode;
            opnd_valid <= next_opnd_valid;
            opnd <= next_opnd;
            left <= next_left;
            dummy_end <= next_dummy_end;
            is_store <= next_is_store;
            test_n <= next_test_n;
        end
    end
endmodule : cbs_sequencer
`default_nettype wire

//--- tb/cbs_sequencer_monitor.sv
// Checker on the sequencer ports.
// Assumes it is bound into every sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer_monitor
    import cbs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] data_in,
    input wire logic [7:0] acc_a,
    input wire logic [7:0] acc_b,
    input wire logic [15:0] addr,
    input wire logic rd_wr,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic [7:0] opcode,
    input wire logic opnd_valid,
    input wire logic [7:0] opnd
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_dummy_read: assert property (addr == DUMMY_ADDR |-> rd_wr)
        else $error("dummy cycle is not a read");
    a_oe_write: assert property (data_oe == !rd_wr)
        else $error("data_oe and rd_wr disagree");
    a_zero_page: assert property (!rd_wr |-> addr[15:8] == DIRECT_PAGE)
        else $error("write outside direct page");
    a_addr_byte: assert property (!rd_wr |-> addr[7:0] == $past(data_in))
        else $error("write address not the fetched byte");
    a_store_data: assert property (!rd_wr |->
        (opcode == OP_STORE_A_DIR && data_out == $past(acc_a))
        || (opcode == OP_STORE_B_DIR && data_out == $past(acc_b)))
        else $error("bad store data");
    a_store_lead: assert property (!rd_wr |-> $past(rd_wr) &&
        $past(rd_wr, 2) && $past(addr) == $past(addr, 2) + 16'h0001)
        else $error("store not led by two reads");
    a_store_next: assert property (!rd_wr |=>
        rd_wr && addr == $past(addr, 2) + 16'h0001) else $error("bad fetch");
    a_dummy_next: assert property (opnd_valid &&
        addr == DUMMY_ADDR |=> addr == $past(addr, 2) + 16'h0001)
        else $error("bad fetch after dummy");
    c_dummy: cover property (addr == DUMMY_ADDR);
    c_store: cover property (!rd_wr);
    c_opnd: cover property (opnd_valid);
endmodule : cbs_sequencer_monitor
bind cbs_sequencer cbs_sequencer_monitor mon (.ref_clk, .rst, .data_in,
    .acc_a, .acc_b, .addr, .rd_wr, .data_out, .data_oe, .opcode,
    .opnd_valid, .opnd);
`default_nettype wire

//--- tb/cbs_mem_model.sv
// Memory on the sequencer bus, preloaded with the test program.
// Assumes read data is wanted in the same cycle as the address.
`timescale 1ns/1ps
`default_nettype none
module cbs_mem_model (
    input wire logic ref_clk,
    input wire logic [15:0] addr,
    input wire logic rd_wr,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic [7:0] data_in
);
    localparam logic [7:0] PROG [23] = '{8'h86, 8'h11, 8'hCC, 8'h12, 8'h34,
        8'hC3, 8'h00, 8'h01, 8'h18, 8'hEC, 8'h00, 8'h00, 8'h1A, 8'h83, 8'h00,
        8'h00, 8'h96, 8'h40, 8'h97, 8'h41, 8'hD7, 8'h42, 8'h00};
    logic [7:0] mem [0:65535];
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h5C;
        foreach (PROG[i]) mem[i] = PROG[i];
    end
    // Bus not read in a write cycle: show garbage, not stale data
    assign data_in = rd_wr ? mem[addr] : ~mem[addr];
    always @(posedge ref_clk) begin
        if (data_oe && !rd_wr) mem[addr] <= data_out;
    end
endmodule : cbs_mem_model
`default_nettype wire

//--- tb/cbs_sequencer_bench.sv
// Self-checking bench for the bus-cycle sequencer.
// Assumes the memory model holds the program from address 0000.
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer_bench;
    import cbs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] acc_a = 8'h3C;
    logic [7:0] acc_b = 8'hC3;
    logic [7:0] data_in, data_out, opcode, opnd;
    logic [15:0] addr;
    logic rd_wr, data_oe, opnd_valid;
    int fails = 0;
    int comparisons = 0;
    // Expected bus cycles: read flag then address
    localparam logic [16:0] ROWS [33] = '{17'h1_0000, 17'h1_0001,
        17'h1_0002, 17'h1_0003, 17'h1_0004, 17'h1_0005, 17'h1_0006,
        17'h1_0007, 17'h1_FFFF, 17'h1_0008, 17'h1_0009, 17'h1_000A,
        17'h1_000B, 17'h1_000C, 17'h1_000D, 17'h1_000E, 17'h1_000F,
        17'h1_FFFF, 17'h1_0010, 17'h1_0011, 17'h1_0040, 17'h1_0012,
        17'h1_0013, 17'h0_0041, 17'h1_0014, 17'h1_0015, 17'h0_0042,
        17'h1_0016, 17'h1_0017, 17'h1_0017, 17'h1_0018, 17'h1_0019,
        17'h1_001A};
    // Operand port at each row: valid flag then the operand byte last latched
    localparam logic [8:0] OPNDS [33] = '{9'h000, 9'h000, 9'h111,
        9'h011, 9'h112, 9'h134, 9'h034, 9'h100, 9'h101, 9'h001, 9'h001,
        9'h001, 9'h100, 9'h100, 9'h000, 9'h000, 9'h100, 9'h100, 9'h000,
        9'h000, 9'h000, 9'h15C, 9'h05C, 9'h05C, 9'h05C, 9'h05C, 9'h05C,
        9'h05C, 9'h05C, 9'h05C, 9'h05C, 9'h05C, 9'h05C};
    cbs_sequencer dut (.ref_clk, .rst, .data_in, .acc_a, .acc_b, .addr,
        .rd_wr, .data_out, .data_oe, .opcode, .opnd_valid, .opnd);
    cbs_mem_model mem_model (.ref_clk, .addr, .rd_wr, .data_out, .data_oe,
        .data_in);
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        repeat (200) @(posedge ref_clk);
        fails++;
        end_sim();
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        foreach (ROWS[i]) begin
            chk({rd_wr, addr}, ROWS[i]);
            chk({8'h00, opnd_valid, opnd}, {8'h00, OPNDS[i]});
            @(negedge ref_clk);
        end
        $display("walk done");
        chk({9'h0, mem_model.mem[16'h0041]}, {9'h0, acc_a});
        chk({9'h0, mem_model.mem[16'h0042]}, {9'h0, acc_b});
        $display("stores done");
        // Self-test keeps counting long after its first five cycles
        for (int i = 0; i < 40; i++) begin
            chk({rd_wr, addr}, {1'b1, 16'h001B + 16'(i)});
            @(negedge ref_clk);
        end
        $display("self-test done");
        rst = 1'b1;
        @(negedge ref_clk);
        chk({rd_wr, addr}, 17'h1_0000);
        chk({7'h0, data_oe, opnd_valid, opcode}, 17'h0_0000);
        rst = 1'b0;
        @(negedge ref_clk);
        chk({rd_wr, addr}, 17'h1_0001);
        $display("reset done");
        end_sim();
    end
endmodule : cbs_sequencer_bench
`default_nettype wire
